// *** hw/pdrd_defines.svh ***
// Constants for the parity DRAM, refresh and decode block.
// Assumes a 10 MHz mclk; included by bare name.
`ifndef PDRD_DEFINES_SVH
`define PDRD_DEFINES_SVH
// Clock and processor phase timing
`define PDRD_CLK_MHZ 10
`define PDRD_PHASE_DIV 4'h9
`define PDRD_P2_START 4'h5
`define PDRD_COL_START 4'h7
`define PDRD_WR_START 4'h8
`define PDRD_RD_LATCH 4'h8
`define PDRD_LATE_WRITE_NS 100
`define PDRD_LATE_WRITE_CYC ((`PDRD_LATE_WRITE_NS * `PDRD_CLK_MHZ) / 1000)
`define PDRD_LATE_START (4'hA - 4'(`PDRD_LATE_WRITE_CYC))
// Refresh: one request per period, phase-two clock divided by 32 toggles
`define PDRD_REFRESH_US 64
`define PDRD_REFRESH_CYC (`PDRD_REFRESH_US * `PDRD_CLK_MHZ)
`define PDRD_REFRESH_DIV ((`PDRD_REFRESH_US * `PDRD_CLK_MHZ) / 20)
// Address map of the processor bus
`define PDRD_UPPER_BANK 3'h0
`define PDRD_LOWER_BANK 3'h2
`define PDRD_PERIPH_SPACE 3'h4
// Wishbone register offsets and reset values
`define PDRD_CTRL_OFS 8'h00
`define PDRD_STATUS_OFS 8'h04
`define PDRD_CTRL_REFRESH_BIT 0
`define PDRD_CTRL_INVERT_BIT 1
`define PDRD_STATUS_PERR_BIT 0
`define PDRD_STATUS_COUNT_LSB 8
`define PDRD_CTRL_RST 2'h1
`endif

// *** hw/pdrd_pkg.sv ***
// Types shared by the parity DRAM, refresh and decode block.
// Assumes the defines header for all numbers.
package pdrd_pkg;
    // Refresh sequencer states
    typedef enum logic [1:0] {
        RF_IDLE = 2'b00,
        RF_ENABLE = 2'b01,
        RF_STROBE = 2'b10,
        RF_ADVANCE = 2'b11
    } pdrd_refresh_type;
endpackage

// *** hw/pdrd_mem_if.sv ***
// Carrier between the controller and its 9-bit RAM array.
// Assumes a single mclk domain on both sides.
`timescale 1ns/1ps
`default_nettype none
interface pdrd_mem_if;
    logic req;
    logic we;
    logic [12:0] addr;
    logic [8:0] wdata;
    logic [8:0] rdata;
    modport ctrl (output req, output we, output addr, output wdata, input rdata);
    modport mem (input req, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** hw/pdrd_ram.sv ***
// Two banks of 4K by 9 words: eight data bits and one parity bit.
// Assumes requests come from the controller on mclk; read data registered.
`timescale 1ns/1ps
`default_nettype none
module pdrd_ram #(
    parameter int DEPTH = 8192
) (
    input wire logic mclk,
    pdrd_mem_if.mem port
);
    logic [8:0] cells [DEPTH];
    logic [8:0] rdata_q;

    // Write or registered read, one access per request
    always_ff @(posedge mclk) begin
        if (port.req && port.we) begin
            cells[port.addr] <= port.wdata;
        end
        if (port.req && !port.we) begin
            rdata_q <= cells[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule // pdrd_ram
`default_nettype wire

// *** hw/parity_dram_refresh_decode.sv ***
// Parity DRAM control, refresh and bus decode for an 8-bit processor board.
// Assumes processor pins are asynchronous to mclk and held through a cycle.
// Operation
// - Memory is two banks of 4K nine-bit words, ninth bit parity.
// - Shared RAM address switches among row, column and refresh sources.
// - Refresh enable and row select high give row; refresh low gives refresh.
// - Six-bit refresh counter advances on each low advance pulse.
// - A refresh cycle is requested every 64 microseconds.
// - Request comes from phase two divided by 32, gated by memory select.
// - Refresh enable low yields advance pulse and refresh row strobe.
// - Address bits 12-14 decode; output 0 upper bank, output 2 lower.
// - Bank row strobe is select AND phase clock, OR refresh row strobe.
// - Memory select is OR of banks; with read it enables data drivers.
// - Column and write strobes reach all chips without bank gating.
// - Writes store an even parity bit with the data.
// - Reads check nine bits together and latch any parity error.
// - Space 4XXX from bits 12-15 enables both peripheral decoders.
// - Read peripheral decoder uses bits 1-3, enabled by bit four high.
// - Write decoder works only on writes, in last 100 ns of phase two.
// - Late-write strobe is NAND of divide-by-five and divide-by-ten.
// - Decoders enabled by valid address OR bus released.
// - Reset initialises decoders and clears status and parity error.
// - Row address goes out first, then column, marked by strobes.
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pdrd_defines.svh"
module parity_dram_refresh_decode (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] cpuAddr,
    input wire logic [7:0] cpuDataIn,
    input wire logic cpuRw,
    input wire logic validAddrFlag,
    input wire logic busReleased,
    output logic [7:0] cpuDataOut,
    output logic cpuDataOe_n,
    output logic memorySelect,
    output logic [5:0] ramAddr,
    output logic upperRowStrobe,
    output logic lowerRowStrobe,
    output logic columnStrobe,
    output logic memoryWriteStrobe,
    output logic rowSelect,
    output logic refreshEnable_n,
    output logic refreshAdvanceStrobe_n,
    output logic refreshRowStrobe,
    output logic [7:0] periphReadSel,
    output logic [7:0] periphWriteSel,
    output logic parityError
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage read only by the second
    logic [26:0] syncA_q, syncB_q;
    always_ff @(posedge mclk) begin
        syncA_q <= {cpuAddr, cpuDataIn, cpuRw, validAddrFlag, busReleased};
        syncB_q <= syncA_q;
    end
    logic [15:0] addr;
    logic [7:0] dataIn;
    logic rdNotWr, valid_addr_flag, bReleased;
    assign {addr, dataIn, rdNotWr, valid_addr_flag, bReleased} = syncB_q;

    ////////////////////////////////////////////////////////////////////////
    // Phase counter: ten mclk per processor cycle, phase two in the upper half
    logic [3:0] phaseCnt_q, phaseNext;
    assign phaseNext = (phaseCnt_q == `PDRD_PHASE_DIV) ? 4'h0 : phaseCnt_q + 4'h1;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phaseCnt_q <= 4'h0;
        end else begin
            phaseCnt_q <= phaseNext;
        end
    end
    logic p2Next, lateNext;
    assign p2Next = phaseNext >= `PDRD_P2_START;
    // Late-write window: both dividers high, only the final slot of phase two
    assign lateNext = phaseNext >= `PDRD_LATE_START;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    logic decEn, bankUpper, bankLower, memSel, periphSpace;
    assign decEn = (valid_addr_flag || bReleased) && !addr[15];
    assign bankUpper = decEn && addr[14:12] == `PDRD_UPPER_BANK;
    assign bankLower = decEn && addr[14:12] == `PDRD_LOWER_BANK;
    assign memSel = bankUpper || bankLower;
    assign periphSpace = decEn && addr[14:12] == `PDRD_PERIPH_SPACE;
    logic [7:0] periphOneHot;
    // One select per peripheral slot from bits 1 to 3
    for (genvar g = 0; g < 8; g++) begin : g_pdec
        assign periphOneHot[g] = addr[3:1] == 3'(g);
    end

    // Peripheral selects, decoders reset to all off
    logic [7:0] periphReadSel_q, periphWriteSel_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            periphReadSel_q <= 8'h00;
            periphWriteSel_q <= 8'h00;
        end else begin
            periphReadSel_q <= (periphSpace && addr[4]) ? periphOneHot : 8'h00;
            periphWriteSel_q <= (periphSpace && !rdNotWr && addr[4] && lateNext)
                ? periphOneHot : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone registers: control bits and sticky parity error
    logic refreshOn_q, parityInvert_q, parityError_q, ack_q;
    logic [31:0] wbDat_q;
    logic [5:0] refCount_q;
    logic wbWrite, perrClear, perrSet;
    assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && ack_q; // Lands at the completing edge
    assign perrClear = wbWrite && wb_adr_i == `PDRD_STATUS_OFS && wb_sel_i[0]
        && wb_dat_i[`PDRD_STATUS_PERR_BIT];

    // Answer every cycle, unmapped reads as zero; ack drops the next cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            wbDat_q <= 32'h0000_0000;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            wbDat_q <= 32'h0000_0000;
            if (wb_adr_i == `PDRD_CTRL_OFS) begin
                wbDat_q[`PDRD_CTRL_REFRESH_BIT] <= refreshOn_q;
                wbDat_q[`PDRD_CTRL_INVERT_BIT] <= parityInvert_q;
            end else if (wb_adr_i == `PDRD_STATUS_OFS) begin
                wbDat_q[`PDRD_STATUS_PERR_BIT] <= parityError_q;
                wbDat_q[`PDRD_STATUS_COUNT_LSB +: 6] <= refCount_q;
            end
        end
    end

    // Control register; the inversion bit exists to provoke parity errors
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {parityInvert_q, refreshOn_q} <= `PDRD_CTRL_RST;
        end else if (wbWrite && wb_adr_i == `PDRD_CTRL_OFS && wb_sel_i[0]) begin
            refreshOn_q <= wb_dat_i[`PDRD_CTRL_REFRESH_BIT];
            parityInvert_q <= wb_dat_i[`PDRD_CTRL_INVERT_BIT];
        end
    end

    // Sticky parity error; a new error beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            parityError_q <= 1'b0;
        end else if (perrSet) begin
            parityError_q <= 1'b1;
        end else if (perrClear) begin
            parityError_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Refresh timing: phase two divided by 32 toggles, one request per period
    logic [5:0] p2Div_q;
    logic refToggle_q, refReq_q, reqTick;
    assign reqTick = phaseNext == `PDRD_P2_START && refToggle_q
        && p2Div_q == 6'(`PDRD_REFRESH_DIV - 1);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            p2Div_q <= 6'h00;
            refToggle_q <= 1'b0;
        end else if (phaseNext == `PDRD_P2_START) begin
            if (p2Div_q == 6'(`PDRD_REFRESH_DIV - 1)) begin
                p2Div_q <= 6'h00;
                refToggle_q <= !refToggle_q;
            end else begin
                p2Div_q <= p2Div_q + 6'h01;
            end
        end
    end

    // Refresh sequencer runs in phase one, only while the RAM is idle
    pdrd_pkg::pdrd_refresh_type rfState_q, rfState_d;
    always_comb begin
        rfState_d = rfState_q;
        unique case (rfState_q)
            pdrd_pkg::RF_IDLE: begin
                if (refReq_q && refreshOn_q && phaseNext == 4'h0 && !memSel) begin
                    rfState_d = pdrd_pkg::RF_ENABLE;
                end
            end
            pdrd_pkg::RF_ENABLE: begin
                rfState_d = pdrd_pkg::RF_STROBE;
            end
            pdrd_pkg::RF_STROBE: begin
                rfState_d = pdrd_pkg::RF_ADVANCE;
            end
            pdrd_pkg::RF_ADVANCE: begin
                rfState_d = pdrd_pkg::RF_IDLE;
            end
        endcase
    end
    logic refEnN_d, refClaim;
    assign refEnN_d = rfState_d == pdrd_pkg::RF_IDLE;
    assign refClaim = rfState_q == pdrd_pkg::RF_IDLE && !refEnN_d;

    // Request flag: a new tick wins over the claim of the old one
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rfState_q <= pdrd_pkg::RF_IDLE;
            refReq_q <= 1'b0;
        end else begin
            rfState_q <= rfState_d;
            if (reqTick) begin
                refReq_q <= 1'b1;
            end else if (refClaim) begin
                refReq_q <= 1'b0;
            end
        end
    end

    // Counter advances as the low advance pulse ends
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            refCount_q <= 6'h00;
        end else if (rfState_q == pdrd_pkg::RF_ADVANCE) begin
            refCount_q <= refCount_q + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM strobes and address mux, all registered from next-phase values
    logic rowSel_d, refRowStrobe_d;
    assign rowSel_d = phaseNext < `PDRD_COL_START;
    assign refRowStrobe_d = rfState_d == pdrd_pkg::RF_STROBE;
    logic upperRas_q, lowerRas_q, cas_q, memory_write_strobe_q, rowSel_q, refEnN_q, advN_q, refRas_q;
    logic memSel_q;
    logic [5:0] ramAddr_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {upperRas_q, lowerRas_q, cas_q, memory_write_strobe_q, refRas_q, memSel_q} <= 6'h00;
            {rowSel_q, refEnN_q, advN_q} <= 3'h7;
            ramAddr_q <= 6'h00;
        end else begin
            upperRas_q <= (bankUpper && p2Next) || refRowStrobe_d;
            lowerRas_q <= (bankLower && p2Next) || refRowStrobe_d;
            cas_q <= memSel && phaseNext >= `PDRD_COL_START;
            memory_write_strobe_q <= memSel && !rdNotWr && phaseNext >= `PDRD_WR_START;
            rowSel_q <= rowSel_d;
            refEnN_q <= refEnN_d;
            refRas_q <= refRowStrobe_d;
            advN_q <= rfState_d != pdrd_pkg::RF_ADVANCE;
            memSel_q <= memSel;
            // Refresh overrides the row/column choice
            ramAddr_q <= !refEnN_d ? refCount_q
                : rowSel_d ? addr[5:0] : addr[11:6];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array access with parity: request at column time, data back next slot
    pdrd_mem_if memBus ();
    logic accRead_q, memRdVal;
    assign memBus.req = memSel && phaseCnt_q == `PDRD_COL_START;
    assign memBus.we = !rdNotWr;
    assign memBus.addr = {bankUpper, addr[11:0]};
    assign memBus.wdata = {^dataIn ^ parityInvert_q, dataIn};
    assign memRdVal = accRead_q && phaseCnt_q == `PDRD_RD_LATCH;
    assign perrSet = memRdVal && ^memBus.rdata;

    pdrd_ram #(.DEPTH(8192)) u_ram (
        .mclk(mclk),
        .port(memBus)
    );

    // Data drivers enabled only for RAM reads, in the last slot of phase two
    logic [7:0] dataOut_q;
    logic oeN_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            accRead_q <= 1'b0;
            dataOut_q <= 8'h00;
            oeN_q <= 1'b1;
        end else begin
            accRead_q <= memBus.req && rdNotWr;
            if (memRdVal) begin
                dataOut_q <= memBus.rdata[7:0];
            end
            oeN_q <= !(memRdVal && memSel && rdNotWr);
        end
    end

    assign wb_dat_o = wbDat_q;
    assign wb_ack_o = ack_q;
    assign cpuDataOut = dataOut_q;
    assign cpuDataOe_n = oeN_q;
    assign memorySelect = memSel_q;
    assign ramAddr = ramAddr_q;
    assign upperRowStrobe = upperRas_q;
    assign lowerRowStrobe = lowerRas_q;
    assign columnStrobe = cas_q;
    assign memoryWriteStrobe = memory_write_strobe_q;
    assign rowSelect = rowSel_q;
    assign refreshEnable_n = refEnN_q;
    assign refreshAdvanceStrobe_n = advN_q;
    assign refreshRowStrobe = refRas_q;
    assign periphReadSel = periphReadSel_q;
    assign periphWriteSel = periphWriteSel_q;
    assign parityError = parityError_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_refresh_addr_mux: assert property (!refEnN_q |-> ramAddr_q == refCount_q)
        else $error("refresh address not on RAM bus");
    a_column_addr_mux: assert property (
        refEnN_q && !rowSel_q |-> ramAddr_q == $past(addr[11:6]))
        else $error("column address not on RAM bus");
    a_counter_advance: assert property (!advN_q |=> refCount_q == $past(refCount_q) + 6'h01
        && advN_q)
        else $error("refresh counter did not advance");
    a_refresh_gated: assert property ($fell(refEnN_q) |-> $past(!memSel))
        else $error("refresh started during RAM access");
    a_strobe_order: assert property ($fell(refEnN_q) |=> refRas_q ##1 !advN_q && !refRas_q
        ##1 advN_q && refEnN_q)
        else $error("refresh strobe sequence wrong");
    a_refresh_both_banks: assert property (refRas_q |-> upperRas_q && lowerRas_q)
        else $error("refresh did not strobe both banks");
    a_read_drive_only: assert property (!oeN_q |-> $past(memSel && rdNotWr))
        else $error("data driven outside a RAM read");
    a_write_parity: assert property (memBus.req && memBus.we
        |-> ^memBus.wdata == parityInvert_q)
        else $error("stored parity not even");
    a_parity_latch: assert property (perrSet |=> parityError_q)
        else $error("parity error not latched");
    a_error_sticky: assert property (parityError_q && !perrClear |=> parityError_q)
        else $error("parity error dropped without clear");
    a_late_write: assert property (|periphWriteSel_q |-> phaseCnt_q == 4'h9
        && $past(!rdNotWr))
        else $error("write select outside late window");

    c_refresh_done: cover property (!advN_q);
    c_parity_error: cover property ($rose(parityError_q));
    c_ram_read: cover property (!oeN_q);
    c_periph_write: cover property (|periphWriteSel_q);
endmodule // parity_dram_refresh_decode
`default_nettype wire

// *** bench/pdrd_cpu_model.sv ***
// Processor bus model: one bus cycle per 1 us processor cycle.
// Assumes the bench count 0..9 runs in step with the block's own count.
`timescale 1ns/1ps
`default_nettype none
module pdrd_cpu_model (
    input wire logic mclk,
    input wire logic [3:0] phase,
    input wire logic reqValid,
    input wire logic [15:0] reqAddr,
    input wire logic [7:0] reqData,
    input wire logic reqRw,
    input wire logic reqDma,
    output var logic [15:0] cpuAddr,
    output var logic [7:0] cpuDataIn,
    output var logic cpuRw,
    output var logic validAddrFlag,
    output var logic busReleased
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero: no valid address, bus not released
    initial begin
        cpuAddr = 16'h0000;
        cpuDataIn = 8'h00;
        cpuRw = 1'b1;
        validAddrFlag = 1'b0;
        busReleased = 1'b0;
    end

    // Lines change only at the wrap to count 0, so they hold for a whole cycle.
    // Undriven address and data lines show an inverting pattern, never a stale copy.
    always @(posedge mclk) begin
        if (phase == 4'h9) begin
            if (reqValid) begin
                cpuAddr <= reqAddr;
                cpuDataIn <= reqData;
                cpuRw <= reqRw;
                validAddrFlag <= !reqDma;
                busReleased <= reqDma;
            end else begin
                cpuAddr <= ~cpuAddr;
                cpuDataIn <= ~cpuDataIn;
                cpuRw <= 1'b1; // Pulled-up line reads high
                validAddrFlag <= 1'b0;
                busReleased <= 1'b0;
            end
        end
    end
endmodule // pdrd_cpu_model
`default_nettype wire

// *** bench/parity_dram_refresh_decode_bench.sv ***
// Self-checking bench for the parity DRAM, refresh and decode block.
// Assumes the block's count 0..9 restarts at the reset release edge.
`timescale 1ns/1ps
`default_nettype none
module parity_dram_refresh_decode_bench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatI = 32'h0, wbDatO;
    logic [3:0] phase = 4'h0;
    logic reqValid = 1'b0, reqRw = 1'b1, reqDma = 1'b0;
    logic [15:0] reqAddr = 16'h0, cpuAddr;
    logic [7:0] reqData = 8'h0, cpuDataIn, cpuDataOut, periphReadSel, periphWriteSel;
    logic cpuRw, validAddrFlag, busReleased, cpuDataOe_n, memorySelect, upperRowStrobe;
    logic lowerRowStrobe, columnStrobe, memoryWriteStrobe, rowSelect, refreshEnable_n;
    logic refreshAdvanceStrobe_n, refreshRowStrobe, parityError;
    logic [5:0] ramAddr;
    int failures = 0;
    int testsRun = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////////
    parity_dram_refresh_decode DUT (
        .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .cpuAddr(cpuAddr), .cpuDataIn(cpuDataIn), .cpuRw(cpuRw),
        .validAddrFlag(validAddrFlag), .busReleased(busReleased), .cpuDataOut(cpuDataOut),
        .cpuDataOe_n(cpuDataOe_n), .memorySelect(memorySelect), .ramAddr(ramAddr),
        .upperRowStrobe(upperRowStrobe), .lowerRowStrobe(lowerRowStrobe),
        .columnStrobe(columnStrobe), .memoryWriteStrobe(memoryWriteStrobe),
        .rowSelect(rowSelect), .refreshEnable_n(refreshEnable_n),
        .refreshAdvanceStrobe_n(refreshAdvanceStrobe_n), .refreshRowStrobe(refreshRowStrobe),
        .periphReadSel(periphReadSel), .periphWriteSel(periphWriteSel),
        .parityError(parityError));
    pdrd_cpu_model cpu (
        .mclk(mclk), .phase(phase), .reqValid(reqValid), .reqAddr(reqAddr),
        .reqData(reqData), .reqRw(reqRw), .reqDma(reqDma), .cpuAddr(cpuAddr),
        .cpuDataIn(cpuDataIn), .cpuRw(cpuRw), .validAddrFlag(validAddrFlag),
        .busReleased(busReleased));

    ////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock and a count that mirrors the block's processor phase
    always #50 mclk = ~mclk;
    always_ff @(posedge mclk) begin
        phase <= (sys_rst || phase == 4'h9) ? 4'h0 : phase + 4'h1;
    end

    // Cuts a hang short; the whole run needs well under 4000 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask

    // Classic single cycle; holds the request until ack is seen at an edge
    task automatic wb_access(input logic we, input logic [7:0] a, input logic [31:0] d,
                             output logic [31:0] q);
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        do @(posedge mclk); while (wbAck !== 1'b1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    // Returns just after the edge that makes the count equal n
    task automatic wait_count(input logic [3:0] n);
        do begin
            @(posedge mclk);
            #1;
        end while (phase !== n);
    endtask

    // Queues one bus cycle; the model presents it from the next count 0
    task automatic cpu_issue(input logic [15:0] a, input logic [7:0] d, input logic rw,
                             input logic dma);
        wait_count(4'h8);
        @(posedge mclk);
        reqValid <= 1'b1;
        reqAddr <= a;
        reqData <= d;
        reqRw <= rw;
        reqDma <= dma;
        @(posedge mclk);
        reqValid <= 1'b0;
    endtask

    // One RAM access, judged at each count of phase two where a strobe rises or the mux changes
    task automatic mem_access(input logic [15:0] a, input logic [7:0] d, input logic rw,
                              input logic dma);
        logic up;
        up = (a[14:12] == 3'h0);
        cpu_issue(a, d, rw, dma);
        wait_count(4'h5);
        check_word(32'(ramAddr), 32'(a[5:0]));
        check_bit(rowSelect, 1'b1);
        check_bit(up ? upperRowStrobe : lowerRowStrobe, 1'b1);
        check_bit(up ? lowerRowStrobe : upperRowStrobe, 1'b0);
        check_bit(memorySelect, 1'b1);
        wait_count(4'h7);
        check_word(32'(ramAddr), 32'(a[11:6]));
        check_bit(rowSelect, 1'b0);
        check_bit(columnStrobe, 1'b1);
        wait_count(4'h8);
        check_bit(memoryWriteStrobe, !rw);
        wait_count(4'h9);
        check_bit(cpuDataOe_n, !rw);
        if (rw) check_word(32'(cpuDataOut), 32'(d));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [31:0] q;
        wait_count(4'h1);
        check_bit(refreshEnable_n, 1'b1);
        check_bit(rowSelect, 1'b1);
        check_bit(parityError, 1'b0);
        check_bit(memorySelect, 1'b0);
        wb_access(1'b0, 8'h04, 32'h0, q);
        check_word(q, 32'h0);
        wb_access(1'b0, 8'h08, 32'h0, q);
        check_word(q, 32'h0);
        wb_access(1'b0, 8'h00, 32'h0, q);
        check_word(q, 32'h1);
        $display("test reset done");
    endtask

    // Both banks, odd and even weights, and a read by a released-bus master
    task automatic test_memory();
        mem_access(16'h0123, 8'hA5, 1'b0, 1'b0);
        mem_access(16'h2FFF, 8'h01, 1'b0, 1'b0);
        mem_access(16'h0123, 8'hA5, 1'b1, 1'b0);
        mem_access(16'h2FFF, 8'h01, 1'b1, 1'b1);
        check_bit(parityError, 1'b0);
        $display("test memory done");
    endtask

    // Inverted parity is stored, then caught on read and held until cleared
    task automatic test_parity();
        logic [31:0] q;
        wb_access(1'b1, 8'h00, 32'h3, q);
        mem_access(16'h0040, 8'h5A, 1'b0, 1'b0);
        wb_access(1'b1, 8'h00, 32'h1, q);
        mem_access(16'h0040, 8'h5A, 1'b1, 1'b0);
        check_bit(parityError, 1'b1);
        mem_access(16'h0123, 8'hA5, 1'b1, 1'b0);
        check_bit(parityError, 1'b1);
        wb_access(1'b0, 8'h04, 32'h0, q);
        check_bit(q[0], 1'b1);
        wb_access(1'b1, 8'h04, 32'h1, q);
        wb_access(1'b0, 8'h04, 32'h0, q);
        check_bit(q[0], 1'b0);
        $display("test parity done");
    endtask

    task automatic test_periph();
        cpu_issue(16'h4016, 8'h00, 1'b1, 1'b0);
        wait_count(4'h5);
        check_word(32'(periphReadSel), 32'h08);
        check_bit(memorySelect, 1'b0);
        cpu_issue(16'h4006, 8'h00, 1'b1, 1'b0);
        wait_count(4'h5);
        check_word(32'(periphReadSel), 32'h00);
        cpu_issue(16'h401A, 8'h00, 1'b0, 1'b0);
        wait_count(4'h8);
        check_word(32'(periphWriteSel), 32'h00);
        wait_count(4'h9);
        check_word(32'(periphWriteSel), 32'h20);
        $display("test periph done");
    endtask

    // Two refreshes on an idle bus: sequence, row advance and spacing
    task automatic test_refresh();
        logic [5:0] r0;
        int n;
        while (refreshEnable_n !== 1'b0) wait_count(4'h0);
        r0 = ramAddr;
        @(posedge mclk);
        #1;
        check_bit(refreshRowStrobe, 1'b1);
        check_bit(upperRowStrobe & lowerRowStrobe, 1'b1);
        @(posedge mclk);
        #1;
        check_bit(refreshAdvanceStrobe_n, 1'b0);
        @(posedge mclk);
        #1;
        check_bit(refreshEnable_n, 1'b1);
        n = 3;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (refreshEnable_n !== 1'b0);
        check_word(32'(n), 32'h280);
        check_word(32'(phase), 32'h0);
        check_word(32'(ramAddr), 32'(6'(r0 + 6'h01)));
        $display("test refresh done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 20 cycles, then each scenario in turn
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        test_reset();
        test_memory();
        test_parity();
        test_periph();
        test_refresh();
        report_and_stop();
    end
endmodule // parity_dram_refresh_decode_bench
`default_nettype wire
